// ### flash_adc_map.svh
// Constants for the flash converter sequencing block
`ifndef FLASH_ADC_MAP_SVH
`define FLASH_ADC_MAP_SVH

// Comparator bank, output word and input width
`define ADC_NUM_COMPARATORS 64
`define ADC_DATA_BITS       6
`define ADC_INPUT_BITS      8

// Input scale: one unit is VREF/256; tap N sits at (2N-1)*VREF/128
`define ADC_TAP_STEP        8'h04
`define ADC_TAP_OFFSET      8'h02

// Reset values and the overflow code
`define ADC_RESULT_RESET    7'h00
`define ADC_LATCH_RESET     64'hffffffffffffffff
`define ADC_OVERFLOW_CODE   7'h7f

// Field positions within the seven-bit code
`define ADC_OVERFLOW_POS    6
`define ADC_DATA_LSB_POS    0
`define ADC_DATA_MSB_POS    5

`endif

// ### flash_adc_pkg.sv
// Types shared by the flash converter sequencing block
package flash_adc_pkg;

  // Internal interval of the converter
  typedef enum logic {
    PH_BALANCE = 1'b0,
    PH_ACQUIRE = 1'b1
  } interval_type;

  // Seven-bit conversion code: overflow above six data bits
  typedef struct packed {
    logic       overflow;
    logic [5:0] bits;
  } code_type;

  // Output enables of the three-state drivers
  typedef struct packed {
    logic dataOe;
    logic overflowOe;
  } drive_type;

endpackage

// ### thermo_decoder.sv
// Thermometer to binary decoder for the comparator bank
`timescale 1ns/100ps
`include "flash_adc_map.svh"

module thermo_decoder
  import flash_adc_pkg::*;
#(
  parameter int NUM_COMP = `ADC_NUM_COMPARATORS
) (
  // Latched comparator pattern, low means tap below input
  input  wire logic [NUM_COMP-1:0] comparators,
  // Decoded code
  output code_type                 code
);

  logic [6:0] tripCount;

  // Counts tripped comparators; a full bank gives overflow
  always_comb begin
    tripCount = 7'h00;
    for (int i = 0; i < NUM_COMP; i++) begin
      tripCount = tripCount + {6'h00, ~comparators[i]};
    end
    if (tripCount == 7'(NUM_COMP)) begin
      code = `ADC_OVERFLOW_CODE;
    end else begin
      code = {1'b0, tripCount[5:0]};
    end
  end

endmodule // thermo_decoder

// ### flash_adc_conversion_timing.sv
// Conversion sequencing of a six-bit flash converter with overflow
`timescale 1ns/100ps
`include "flash_adc_map.svh"

module flash_adc_conversion_timing
  import flash_adc_pkg::*;
#(
  parameter int NUM_COMP = `ADC_NUM_COMPARATORS,
  parameter int IN_W     = `ADC_INPUT_BITS
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            resetn,
  // Converter clock and polarity control
  input  wire logic            convClk,
  input  wire logic            phaseCtrl,
  // Sampled input level, units of one quarter LSB
  input  wire logic [IN_W-1:0] analogInput,
  // Output enables
  input  wire logic            dataBitsDisable,
  input  wire logic            allOutputsEnableN,
  // Data outputs, bit 0 is the least significant
  output logic [5:0]           resultBits,
  output logic                 resultBitsOe,
  // Overflow output
  output logic                 overflowFlag,
  output logic                 overflowFlagOe,
  // Current interval and load strobe
  output interval_type         interval,
  output logic                 resultLoad
);

  ////////////////////////////////////////////////////////////////////////
  // Interval selection

  interval_type intervalNow;
  interval_type interval_q;
  logic         acquireStart;
  logic         acquireEnd;

  // Polarity complements the clock as it enters
  always_comb begin
    if (convClk ~^ phaseCtrl) begin
      intervalNow = PH_ACQUIRE;
    end else begin
      intervalNow = PH_BALANCE;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      interval_q <= PH_BALANCE;
    end else begin
      interval_q <= intervalNow;
    end
  end

  assign acquireStart = (intervalNow == PH_ACQUIRE) &&
                        (interval_q == PH_BALANCE);
  assign acquireEnd   = (intervalNow == PH_BALANCE) &&
                        (interval_q == PH_ACQUIRE);
  assign interval     = interval_q;

  ////////////////////////////////////////////////////////////////////////
  // Comparator bank

  logic [NUM_COMP-1:0] comparators;
  logic [NUM_COMP-1:0] latch_q;

  generate
    for (genvar n = 0; n < NUM_COMP; n++) begin : g_comp
      localparam logic [IN_W:0] TAP =
        (IN_W+1)'((n + 1) * `ADC_TAP_STEP - `ADC_TAP_OFFSET);
      // Low only when the tap lies below the input
      assign comparators[n] = !(TAP < {1'b0, analogInput});
    end
  endgenerate

  // Latches track through acquire, freeze through balance
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= `ADC_LATCH_RESET;
    end else if (intervalNow == PH_ACQUIRE) begin
      latch_q <= comparators;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode and output register

  code_type decoded;
  code_type result_q;

  thermo_decoder #(
    .NUM_COMP    (NUM_COMP)
  ) u_decoder (
    .comparators (latch_q),
    .code        (decoded)
  );

  // Loaded once per period, at the start of acquire
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      result_q <= `ADC_RESULT_RESET;
    end else if (acquireStart) begin
      result_q <= decoded;
    end
  end

  assign resultLoad   = acquireStart;
  assign resultBits   = result_q.bits;
  assign overflowFlag = result_q.overflow;

  ////////////////////////////////////////////////////////////////////////
  // Three-state enables

  drive_type drive;

  always_comb begin
    drive.overflowOe = allOutputsEnableN;
    drive.dataOe     = allOutputsEnableN && !dataBitsDisable;
  end

  assign resultBitsOe   = drive.dataOe;
  assign overflowFlagOe = drive.overflowOe;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  chk_interval_polarity: assert property (
    @(posedge mclk) disable iff (!resetn)
    $past(resetn) |->
      (interval_q == PH_ACQUIRE) == $past(convClk ~^ phaseCtrl))
    else $error("interval does not follow clock and polarity");

  chk_polarity_invert: assert property (
    @(posedge mclk) disable iff (!resetn)
    $changed(phaseCtrl) && $stable(convClk) |=>
      interval_q != $past(interval_q))
    else $error("polarity change did not flip the interval");

  chk_comp_thermo: assert property (
    @(posedge mclk) disable iff (!resetn)
    ((comparators << 1) & ~comparators) == '0)
    else $error("comparator pattern is not a thermometer");

  chk_latch_track: assert property (
    @(posedge mclk) disable iff (!resetn)
    intervalNow == PH_ACQUIRE |=> latch_q == $past(comparators))
    else $error("latches not transparent in acquire");

  chk_latch_hold: assert property (
    @(posedge mclk) disable iff (!resetn)
    acquireEnd ##1 (intervalNow == PH_BALANCE) [*2] |=> $stable(latch_q))
    else $error("latched pattern moved during balance");

  chk_load_value: assert property (
    @(posedge mclk) disable iff (!resetn)
    acquireStart |=> result_q == $past(decoded))
    else $error("output register missed decoded code");

  chk_load_once: assert property (
    @(posedge mclk) disable iff (!resetn)
    !acquireStart |=> $stable(result_q))
    else $error("output register changed outside acquire start");

  chk_pulse_convert: assert property (
    @(posedge mclk) disable iff (!resetn)
    acquireEnd ##1 (intervalNow == PH_BALANCE) ##1 acquireStart |=>
      result_q == $past(decoded) && $past(latch_q) == $past(latch_q, 2))
    else $error("single balance pulse did not convert held sample");

  chk_data_hiz: assert property (
    @(posedge mclk) disable iff (!resetn)
    dataBitsDisable && allOutputsEnableN |->
      !resultBitsOe && overflowFlagOe)
    else $error("data disable misdrives the outputs");

  chk_all_hiz: assert property (
    @(posedge mclk) disable iff (!resetn)
    !allOutputsEnableN |-> !resultBitsOe && !overflowFlagOe)
    else $error("outputs driven while all outputs disabled");

  chk_overflow_code: assert property (
    @(posedge mclk) disable iff (!resetn)
    overflowFlag |-> resultBits == 6'h3f)
    else $error("overflow without all data bits high");

  chk_count_code: assert property (
    @(posedge mclk) disable iff (!resetn)
    acquireStart && latch_q[0] |=> resultBits == 6'h00 && !overflowFlag)
    else $error("empty trip count did not give zero");

  ////////////////////////////////////////////////////////////////////////
  // Output, sequencing and comparator checks

  chk_load_pulse: assert property (
    @(posedge mclk) disable iff (!resetn)
    resultLoad |=> !resultLoad)
    else $error("load strobe longer than one cycle");

  chk_load_interval: assert property (
    @(posedge mclk) disable iff (!resetn)
    resultLoad |=> interval == PH_ACQUIRE)
    else $error("load not followed by acquire");

  chk_edge_load: assert property (
    @(posedge mclk) disable iff (!resetn)
    interval == PH_BALANCE && (convClk ~^ phaseCtrl) |-> resultLoad)
    else $error("acquire start without load strobe");

  chk_balance_noload: assert property (
    @(posedge mclk) disable iff (!resetn)
    !(convClk ~^ phaseCtrl) |-> !resultLoad)
    else $error("load strobe during balance");

  chk_balance_latch: assert property (
    @(posedge mclk) disable iff (!resetn)
    !(convClk ~^ phaseCtrl) |=> $stable(latch_q))
    else $error("latches moved during balance");

  chk_result_stand: assert property (
    @(posedge mclk) disable iff (!resetn)
    !resultLoad |=> $stable({overflowFlag, resultBits}))
    else $error("result changed without load strobe");

  chk_acquire_hold: assert property (
    @(posedge mclk) disable iff (!resetn)
    interval == PH_ACQUIRE |=> $stable({overflowFlag, resultBits}))
    else $error("result changed while idling in acquire");

  chk_balance_out: assert property (
    @(posedge mclk) disable iff (!resetn)
    interval == PH_BALANCE && !(convClk ~^ phaseCtrl) |=>
      $stable(resultBits))
    else $error("result changed during balance");

  chk_data_drive: assert property (
    @(posedge mclk) disable iff (!resetn)
    allOutputsEnableN && !dataBitsDisable |-> resultBitsOe)
    else $error("data outputs not driven when enabled");

  chk_flag_drive: assert property (
    @(posedge mclk) disable iff (!resetn)
    allOutputsEnableN |-> overflowFlagOe)
    else $error("overflow not driven when enabled");

  chk_oe_order: assert property (
    @(posedge mclk) disable iff (!resetn)
    resultBitsOe |-> overflowFlagOe)
    else $error("data driven while overflow released");

  chk_data_release: assert property (
    @(posedge mclk) disable iff (!resetn)
    !resultBitsOe |-> dataBitsDisable || !allOutputsEnableN)
    else $error("data released without a disable");

  chk_flag_release: assert property (
    @(posedge mclk) disable iff (!resetn)
    !overflowFlagOe |-> !allOutputsEnableN)
    else $error("overflow released while enabled");

  chk_overflow_full: assert property (
    @(posedge mclk) disable iff (!resetn)
    acquireStart && latch_q == '0 |=>
      overflowFlag && resultBits == 6'h3f)
    else $error("full trip count did not give overflow");

  chk_no_overflow: assert property (
    @(posedge mclk) disable iff (!resetn)
    acquireStart && latch_q[NUM_COMP-1] |=> !overflowFlag)
    else $error("overflow with top comparator untripped");

  chk_latch_thermo: assert property (
    @(posedge mclk) disable iff (!resetn)
    ((latch_q << 1) & ~latch_q) == '0)
    else $error("latched pattern is not a thermometer");

  chk_comp_low_end: assert property (
    @(posedge mclk) disable iff (!resetn)
    {1'b0, analogInput} <= (IN_W+1)'(`ADC_TAP_OFFSET) |->
      comparators == '1)
    else $error("comparator tripped below the lowest tap");

  chk_comp_high_end: assert property (
    @(posedge mclk) disable iff (!resetn)
    {1'b0, analogInput} >
      (IN_W+1)'(NUM_COMP * `ADC_TAP_STEP - `ADC_TAP_OFFSET) |->
      comparators == '0)
    else $error("comparator untripped above the highest tap");

endmodule // flash_adc_conversion_timing

// ### conv_clock_model.sv
// Controller model that strobes the converter clock in pulse modes
`timescale 1ns/100ps

module conv_clock_model (
  // System clock
  input  wire logic       mclk,
  // Strobe set-up
  input  wire logic       phaseCtrl,
  input  wire logic       idleAcquire,
  input  wire logic [1:0] pulses,
  input  wire logic       go,
  // Converter clock and status
  output logic            convClk,
  output logic            busy
);
  logic pulseOn = 1'b0;
  logic busyQ = 1'b0;

  assign busy = busyQ;

  // Idle level is acquire or balance, each pulse flips to the other
  assign convClk = (idleAcquire ? phaseCtrl : ~phaseCtrl) ^ pulseOn;

  //////////////////////////////////////////////////////////////////////////
  always begin
    @(negedge mclk iff go);
    busyQ = 1'b1;
    repeat (pulses) begin
      pulseOn = 1'b1;
      repeat (2) @(negedge mclk);
      pulseOn = 1'b0;
      repeat (2) @(negedge mclk);
    end
    busyQ = 1'b0;
  end
endmodule // conv_clock_model

// ### flash_adc_conversion_timing_tb.sv
// Self-checking bench for the flash converter sequencing block
`timescale 1ns/100ps

module flash_adc_conversion_timing_tb
  import flash_adc_pkg::*;
;
  typedef struct packed {
    logic [7:0] level;
    logic [6:0] code;
    logic       phase;
    logic       idleAcq;
    logic [1:0] count;
  } row_type;

  logic         mclk = 1'b0;
  logic         resetn = 1'b0;
  logic         phaseCtrl = 1'b0;
  logic         idleAcquire = 1'b1;
  logic         go = 1'b0;
  logic [1:0]   pulses = 2'h1;
  logic [7:0]   analogInput = 8'h00;
  logic         dataBitsDisable = 1'b0;
  logic         allOutputsEnableN = 1'b1;
  logic         convClk, busy, resultBitsOe, overflowFlag;
  logic         overflowFlagOe, resultLoad;
  logic [5:0]   resultBits;
  interval_type interval;
  int           fails = 0;
  int           comparisons = 0;
  int           loads = 0;
  row_type      rows [8] = '{
    '{8'h28, 7'h0a, 1'b1, 1'b1, 2'h1}, '{8'hff, 7'h7f, 1'b0, 1'b1, 2'h1},
    '{8'hfe, 7'h3f, 1'b1, 1'b0, 2'h2}, '{8'h03, 7'h01, 1'b0, 1'b0, 2'h2},
    '{8'h02, 7'h00, 1'b1, 1'b1, 2'h2}, '{8'h82, 7'h20, 1'b0, 1'b1, 2'h2},
    '{8'h7d, 7'h1f, 1'b1, 1'b1, 2'h1}, '{8'hf9, 7'h3e, 1'b0, 1'b1, 2'h3}};

  always #2 mclk = ~mclk;
  always @(posedge mclk) if (resultLoad === 1'b1) loads++;

  conv_clock_model model_u (.mclk(mclk), .phaseCtrl(phaseCtrl),
    .idleAcquire(idleAcquire), .pulses(pulses), .go(go),
    .convClk(convClk), .busy(busy));

  flash_adc_conversion_timing dut_u (.mclk(mclk), .resetn(resetn),
    .convClk(convClk), .phaseCtrl(phaseCtrl), .analogInput(analogInput),
    .dataBitsDisable(dataBitsDisable),
    .allOutputsEnableN(allOutputsEnableN), .resultBits(resultBits),
    .resultBitsOe(resultBitsOe), .overflowFlag(overflowFlag),
    .overflowFlagOe(overflowFlagOe), .interval(interval),
    .resultLoad(resultLoad));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [6:0] exp, logic [6:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic convert();
    int n;
    go <= 1'b1;
    @(negedge mclk);
    go <= 1'b0;
    @(negedge mclk);
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40) fails++;
    @(negedge mclk);
  endtask

  task automatic complete_run();
    $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #8000;
    fails++;
    complete_run();
  end

  initial begin
    repeat (11) @(negedge mclk);
    check("reset code", 7'h00, {overflowFlag, resultBits});
    check("reset interval", 7'(PH_BALANCE), 7'(interval));
    @(negedge mclk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      phaseCtrl <= rows[i].phase;
      idleAcquire <= rows[i].idleAcq;
      pulses <= rows[i].count;
      analogInput <= rows[i].level;
      repeat (3) @(negedge mclk);
      loads = 0;
      convert();
      check("code", rows[i].code, {overflowFlag, resultBits});
      check("loads", 7'(rows[i].count), 7'(loads));
      check("interval", 7'(rows[i].idleAcq), 7'(interval));
      $display("Row %0d done", i);
    end
    for (int k = 0; k < 4; k++) begin
      dataBitsDisable <= k[0];
      allOutputsEnableN <= k[1];
      @(negedge mclk);
      check("data oe", 7'(k[1] & ~k[0]), 7'(resultBitsOe));
      check("flag oe", 7'(k[1]), 7'(overflowFlagOe));
    end
    $display("Enable test done");
    // Input change during balance must not reach the result
    phaseCtrl <= 1'b1;
    analogInput <= 8'h28;
    repeat (3) @(negedge mclk);
    idleAcquire <= 1'b0;
    analogInput <= 8'hff;
    repeat (2) @(negedge mclk);
    idleAcquire <= 1'b1;
    repeat (2) @(negedge mclk);
    check("held code", 7'h0a, {overflowFlag, resultBits});
    $display("Balance hold test done");
    resetn <= 1'b0;
    @(negedge mclk);
    check("mid reset", 7'h00, {overflowFlag, resultBits});
    resetn <= 1'b1;
    repeat (2) @(negedge mclk);
    check("after reset", 7'h00, {overflowFlag, resultBits});
    check("interval after reset", 7'(PH_ACQUIRE), 7'(interval));
    $display("Reset test done");
    complete_run();
  end
endmodule // flash_adc_conversion_timing_tb
